// [gpio_pin_model.sv]
// partner model: pin wires of the three ports, core drive against external circuitry
`timescale 1ns/10ps
module gpio_pin_model (
	// core drive
	input  wire gpio_pkg::gpio_pin_drive_t a_drv,
	input  wire gpio_pkg::gpio_pin_drive_t b_drv,
	input  wire gpio_pkg::gpio_pin_drive_t c_drv,
	// external circuitry
	input  wire logic [3:0]                a_ext,
	input  wire logic [3:0]                b_ext,
	input  wire logic [3:0]                c_ext,
	// resolved levels
	output logic [3:0]                     a_pin,
	output logic [3:0]                     b_pin,
	output logic [3:0]                     c_pin
);
	// push-pull: a driving core wins, otherwise the outside level shows
	assign a_pin = (a_drv.oe & a_drv.out) | (~a_drv.oe & a_ext);
	assign b_pin = (b_drv.oe & b_drv.out) | (~b_drv.oe & b_ext);
	assign c_pin = (c_drv.oe & c_drv.out) | (~c_drv.oe & c_ext);
endmodule

// [gpio_pkg.sv]
// package: register locations, field positions, reset values and carrier types for the port block
package gpio_pkg;
	// ************************************************************
	// data-memory bank 0 port locations
	// ************************************************************
	localparam logic [6:0] first_port_addr  = 7'h70;
	localparam logic [6:0] second_port_addr = 7'h71;
	localparam logic [6:0] third_port_addr  = 7'h72;
	// ************************************************************
	// register-file locations
	// ************************************************************
	localparam logic [6:0] rf_analog_sel_addr  = 7'h23;
	localparam logic [6:0] rf_group_dir_addr   = 7'h24;
	localparam logic [6:0] rf_third_dir_addr   = 7'h34;
	localparam logic [6:0] rf_first_dir_addr   = 7'h35;
	localparam logic [6:0] rf_cmp_channel_addr = 7'h1C;
	// ************************************************************
	// field positions and reset values
	// ************************************************************
	localparam int         group_dir_bit     = 0;
	localparam int         cmp_channel_lo    = 0;
	localparam logic [3:0] latch_reset       = 4'h0;
	localparam logic [3:0] dir_reset         = 4'h0;
	localparam logic [3:0] analog_sel_reset  = 4'h0;
	localparam logic [1:0] cmp_channel_reset = 2'h0;
	// ************************************************************
	// carrier types
	// ************************************************************
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [3:0] wdata;
	} gpio_access_t;
	typedef struct packed {
		logic [3:0] out;
		logic [3:0] oe;
	} gpio_pin_drive_t;
endpackage

// [gpio_ports.sv]
// gpio_ports: three 4-bit ports with direction control and comparator routing on the third
`timescale 1ns/10ps
module gpio_ports (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      reset,
	// data-memory bank 0 access from core
	input  wire gpio_pkg::gpio_access_t    dm_acc,
	input  wire logic                      dm_bank_zero,
	output logic [3:0]                     dm_rdata,
	// register-file access from core
	input  wire gpio_pkg::gpio_access_t    rf_acc,
	output logic [3:0]                     rf_rdata,
	// pins
	input  wire logic [3:0]                first_port_in,
	output gpio_pkg::gpio_pin_drive_t      first_port_drv,
	input  wire logic [3:0]                second_port_in,
	output gpio_pkg::gpio_pin_drive_t      second_port_drv,
	input  wire logic [3:0]                third_port_in,
	output gpio_pkg::gpio_pin_drive_t      third_port_drv,
	// comparator side
	output logic [3:0]                     cmp_analog_en,
	output logic [1:0]                     cmp_channel,
	output logic                           cmp_channel_valid
);
	// ************************************************************
	// state
	// ************************************************************
	logic [3:0] first_latch;
	logic [3:0] second_latch;
	logic [3:0] third_latch;
	logic [3:0] first_port_dir_bit;
	logic       second_port_group_dir;
	logic [3:0] third_port_dir_bit;
	logic [3:0] third_port_analog_select;
	logic [1:0] comparator_channel_sel;
	logic       dm_wr_first;
	logic       dm_wr_second;
	logic       dm_wr_third;
	logic [3:0] second_dir_vec;
	logic [3:0] first_view;
	logic [3:0] second_view;
	logic [3:0] third_view;

	// ************************************************************
	// bank 0 decode
	// ************************************************************
	assign dm_wr_first  = dm_acc.wr && dm_bank_zero && dm_acc.addr == gpio_pkg::first_port_addr;
	assign dm_wr_second = dm_acc.wr && dm_bank_zero && dm_acc.addr == gpio_pkg::second_port_addr;
	assign dm_wr_third  = dm_acc.wr && dm_bank_zero && dm_acc.addr == gpio_pkg::third_port_addr;
	assign second_dir_vec = {4{second_port_group_dir}};

	// ************************************************************
	// output latches
	// ************************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			first_latch <= gpio_pkg::latch_reset;
		end else if (dm_wr_first) begin
			first_latch <= dm_acc.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			second_latch <= gpio_pkg::latch_reset;
		end else if (dm_wr_second) begin
			second_latch <= dm_acc.wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			third_latch <= gpio_pkg::latch_reset;
		end else if (dm_wr_third) begin
			third_latch <= dm_acc.wdata;
		end
	end

	// ************************************************************
	// register-file control bits
	// ************************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			first_port_dir_bit       <= gpio_pkg::dir_reset;
			second_port_group_dir    <= gpio_pkg::dir_reset[gpio_pkg::group_dir_bit];
			third_port_dir_bit       <= gpio_pkg::dir_reset;
			third_port_analog_select <= gpio_pkg::analog_sel_reset;
			comparator_channel_sel   <= gpio_pkg::cmp_channel_reset;
		end else if (rf_acc.wr) begin
			if (rf_acc.addr == gpio_pkg::rf_first_dir_addr) begin
				first_port_dir_bit <= rf_acc.wdata;
			end else if (rf_acc.addr == gpio_pkg::rf_group_dir_addr) begin
				second_port_group_dir <= rf_acc.wdata[gpio_pkg::group_dir_bit];
			end else if (rf_acc.addr == gpio_pkg::rf_third_dir_addr) begin
				third_port_dir_bit <= rf_acc.wdata;
			end else if (rf_acc.addr == gpio_pkg::rf_analog_sel_addr) begin
				third_port_analog_select <= rf_acc.wdata;
			end else if (rf_acc.addr == gpio_pkg::rf_cmp_channel_addr) begin
				comparator_channel_sel <= rf_acc.wdata[gpio_pkg::cmp_channel_lo +: 2];
			end
		end
	end

	// ************************************************************
	// pin drive and read views
	// ************************************************************
	assign first_port_drv.out  = first_latch;
	assign first_port_drv.oe   = first_port_dir_bit;
	assign second_port_drv.out = second_latch;
	assign second_port_drv.oe  = second_dir_vec;
	assign third_port_drv.out  = third_latch;
	assign third_port_drv.oe   = third_port_dir_bit;

	assign first_view  = (first_port_dir_bit & first_latch) | (~first_port_dir_bit & first_port_in);
	assign second_view = (second_dir_vec & second_latch) | (~second_dir_vec & second_port_in);
	assign third_view  = (third_port_dir_bit & third_latch) | (~third_port_dir_bit & third_port_in);

	// ************************************************************
	// read data
	// ************************************************************
	always_ff @(posedge clk) begin
		if (reset) begin
			dm_rdata <= 4'h0;
		end else if (dm_acc.rd && dm_bank_zero && dm_acc.addr == gpio_pkg::first_port_addr) begin
			dm_rdata <= first_view;
		end else if (dm_acc.rd && dm_bank_zero && dm_acc.addr == gpio_pkg::second_port_addr) begin
			dm_rdata <= second_view;
		end else if (dm_acc.rd && dm_bank_zero && dm_acc.addr == gpio_pkg::third_port_addr) begin
			dm_rdata <= third_view;
		end else begin
			dm_rdata <= 4'h0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rf_rdata <= 4'h0;
		end else if (rf_acc.rd && rf_acc.addr == gpio_pkg::rf_first_dir_addr) begin
			rf_rdata <= first_port_dir_bit;
		end else if (rf_acc.rd && rf_acc.addr == gpio_pkg::rf_group_dir_addr) begin
			rf_rdata <= {3'h0, second_port_group_dir};
		end else if (rf_acc.rd && rf_acc.addr == gpio_pkg::rf_third_dir_addr) begin
			rf_rdata <= third_port_dir_bit;
		end else if (rf_acc.rd && rf_acc.addr == gpio_pkg::rf_analog_sel_addr) begin
			rf_rdata <= third_port_analog_select;
		end else if (rf_acc.rd && rf_acc.addr == gpio_pkg::rf_cmp_channel_addr) begin
			rf_rdata <= {2'h0, comparator_channel_sel};
		end else begin
			rf_rdata <= 4'h0;
		end
	end

	// ************************************************************
	// comparator routing
	// ************************************************************
	assign cmp_analog_en     = third_port_analog_select;
	assign cmp_channel       = comparator_channel_sel;
	assign cmp_channel_valid = third_port_analog_select[comparator_channel_sel];

	// ************************************************************
	// checks
	// ************************************************************
	property p_first_write;
		@(posedge clk) disable iff (reset)
		dm_wr_first |=> first_latch == $past(dm_acc.wdata);
	endproperty
	a_first_write: assert property (p_first_write) else $error("first latch missed a write");

	property p_first_read_in;
		@(posedge clk) disable iff (reset)
		(dm_acc.rd && dm_bank_zero && dm_acc.addr == gpio_pkg::first_port_addr)
			|=> ((dm_rdata ^ $past(first_port_in)) & ~$past(first_port_dir_bit)) == 4'h0;
	endproperty
	a_first_read_in: assert property (p_first_read_in) else $error("first port input read wrong");

	property p_first_read_out;
		@(posedge clk) disable iff (reset)
		(dm_acc.rd && dm_bank_zero && dm_acc.addr == gpio_pkg::first_port_addr)
			|=> ((dm_rdata ^ $past(first_latch)) & $past(first_port_dir_bit)) == 4'h0;
	endproperty
	a_first_read_out: assert property (p_first_read_out) else $error("first port output read wrong");

	property p_write_while_input;
		@(posedge clk) disable iff (reset)
		(dm_wr_third && third_port_dir_bit == 4'h0)
			|=> third_port_drv.out == $past(dm_acc.wdata) && third_port_drv.oe == 4'h0;
	endproperty
	a_write_while_input: assert property (p_write_while_input) else $error("latch lost input-mode write");

	property p_reset_clear;
		@(posedge clk)
		reset |=> first_port_drv.oe == 4'h0 && second_port_drv.oe == 4'h0 && third_port_drv.oe == 4'h0
			&& first_latch == 4'h0 && second_latch == 4'h0 && third_latch == 4'h0 && cmp_analog_en == 4'h0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset left state set");

	property p_group_dir;
		@(posedge clk) disable iff (reset)
		(rf_acc.wr && rf_acc.addr == gpio_pkg::rf_group_dir_addr)
			|=> second_port_drv.oe == {4{$past(rf_acc.wdata[gpio_pkg::group_dir_bit])}};
	endproperty
	a_group_dir: assert property (p_group_dir) else $error("group direction not applied");

	property p_second_read;
		@(posedge clk) disable iff (reset)
		(dm_acc.rd && dm_bank_zero && dm_acc.addr == gpio_pkg::second_port_addr)
			|=> dm_rdata == ($past(second_port_group_dir) ? $past(second_latch) : $past(second_port_in));
	endproperty
	a_second_read: assert property (p_second_read) else $error("second port read wrong");

	property p_analog_sel;
		@(posedge clk) disable iff (reset)
		(rf_acc.wr && rf_acc.addr == gpio_pkg::rf_analog_sel_addr) |=> cmp_analog_en == $past(rf_acc.wdata);
	endproperty
	a_analog_sel: assert property (p_analog_sel) else $error("analog select not applied");

	property p_third_read;
		@(posedge clk) disable iff (reset)
		(dm_acc.rd && dm_bank_zero && dm_acc.addr == gpio_pkg::third_port_addr)
			|=> dm_rdata == (($past(third_port_dir_bit) & $past(third_latch))
				| (~$past(third_port_dir_bit) & $past(third_port_in)));
	endproperty
	a_third_read: assert property (p_third_read) else $error("third port read wrong");

	property p_channel;
		@(posedge clk) disable iff (reset)
		(rf_acc.wr && rf_acc.addr == gpio_pkg::rf_cmp_channel_addr) |=> cmp_channel == $past(rf_acc.wdata[1:0]);
	endproperty
	a_channel: assert property (p_channel) else $error("channel not applied");

	// ************************************************************
	// further checks: writes, decode refusals, read-back and reset
	// ************************************************************
	property p_second_write;
		@(posedge clk) disable iff (reset)
		dm_wr_second |=> second_port_drv.out == $past(dm_acc.wdata);
	endproperty
	a_second_write: assert property (p_second_write) else $error("second latch missed a write");

	property p_third_write;
		@(posedge clk) disable iff (reset)
		dm_wr_third |=> third_port_drv.out == $past(dm_acc.wdata);
	endproperty
	a_third_write: assert property (p_third_write) else $error("third latch missed a write");

	property p_other_bank;
		@(posedge clk) disable iff (reset)
		(dm_acc.wr && !dm_bank_zero)
			|=> $stable(first_port_drv.out) && $stable(second_port_drv.out) && $stable(third_port_drv.out);
	endproperty
	a_other_bank: assert property (p_other_bank) else $error("write outside bank 0 reached a latch");

	property p_first_dir;
		@(posedge clk) disable iff (reset)
		(rf_acc.wr && rf_acc.addr == gpio_pkg::rf_first_dir_addr)
			|=> first_port_drv.oe == $past(rf_acc.wdata);
	endproperty
	a_first_dir: assert property (p_first_dir) else $error("first direction not applied");

	property p_third_dir;
		@(posedge clk) disable iff (reset)
		(rf_acc.wr && rf_acc.addr == gpio_pkg::rf_third_dir_addr)
			|=> third_port_drv.oe == $past(rf_acc.wdata);
	endproperty
	a_third_dir: assert property (p_third_dir) else $error("third direction not applied");

	property p_analog_keeps_drive;
		@(posedge clk) disable iff (reset)
		(rf_acc.wr && rf_acc.addr == gpio_pkg::rf_analog_sel_addr) |=> $stable(third_port_drv.oe);
	endproperty
	a_analog_keeps_drive: assert property (p_analog_keeps_drive) else $error("analog select changed drive");

	property p_dm_unmapped;
		@(posedge clk) disable iff (reset)
		(dm_acc.rd && !(dm_bank_zero && (dm_acc.addr == gpio_pkg::first_port_addr
			|| dm_acc.addr == gpio_pkg::second_port_addr || dm_acc.addr == gpio_pkg::third_port_addr)))
			|=> dm_rdata == 4'h0;
	endproperty
	a_dm_unmapped: assert property (p_dm_unmapped) else $error("unmapped port read not zero");

	property p_rf_unmapped;
		@(posedge clk) disable iff (reset)
		(rf_acc.rd && rf_acc.addr != gpio_pkg::rf_analog_sel_addr
			&& rf_acc.addr != gpio_pkg::rf_group_dir_addr && rf_acc.addr != gpio_pkg::rf_third_dir_addr
			&& rf_acc.addr != gpio_pkg::rf_first_dir_addr && rf_acc.addr != gpio_pkg::rf_cmp_channel_addr)
			|=> rf_rdata == 4'h0;
	endproperty
	a_rf_unmapped: assert property (p_rf_unmapped) else $error("unmapped control read not zero");

	property p_rf_dir_read;
		@(posedge clk) disable iff (reset)
		(rf_acc.rd && rf_acc.addr == gpio_pkg::rf_first_dir_addr)
			|=> rf_rdata == $past(first_port_drv.oe);
	endproperty
	a_rf_dir_read: assert property (p_rf_dir_read) else $error("first direction read back wrong");

	property p_group_read;
		@(posedge clk) disable iff (reset)
		(rf_acc.rd && rf_acc.addr == gpio_pkg::rf_group_dir_addr)
			|=> rf_rdata == {3'h0, $past(second_port_group_dir)};
	endproperty
	a_group_read: assert property (p_group_read) else $error("group direction read back wrong");

	property p_reset_second;
		@(posedge clk)
		reset |=> second_port_drv.oe == 4'h0 && second_port_drv.out == 4'h0;
	endproperty
	a_reset_second: assert property (p_reset_second) else $error("reset left second port set");

	property p_reset_third;
		@(posedge clk)
		reset |=> third_port_drv.oe == 4'h0 && third_port_drv.out == 4'h0
			&& cmp_analog_en == 4'h0 && cmp_channel == 2'h0;
	endproperty
	a_reset_third: assert property (p_reset_third) else $error("reset left third port set");

	property p_third_analog_in;
		@(posedge clk) disable iff (reset)
		(dm_acc.rd && dm_bank_zero && dm_acc.addr == gpio_pkg::third_port_addr)
			|=> ((dm_rdata ^ $past(third_port_in)) & $past(cmp_analog_en) & ~$past(third_port_drv.oe)) == 4'h0;
	endproperty
	a_third_analog_in: assert property (p_third_analog_in) else $error("analog input pin read wrong");

	property p_third_analog_out;
		@(posedge clk) disable iff (reset)
		(dm_acc.rd && dm_bank_zero && dm_acc.addr == gpio_pkg::third_port_addr)
			|=> ((dm_rdata ^ $past(third_port_drv.out)) & $past(cmp_analog_en) & $past(third_port_drv.oe)) == 4'h0;
	endproperty
	a_third_analog_out: assert property (p_third_analog_out) else $error("analog output pin read wrong");

	c_first_out: cover property (@(posedge clk) disable iff (reset) dm_wr_first ##1 first_port_drv.oe != 4'h0);
	c_second_out: cover property (@(posedge clk) disable iff (reset) second_port_group_dir && dm_wr_second);
	c_analog_in: cover property (@(posedge clk) disable iff (reset) cmp_channel_valid && third_port_drv.oe == 4'h0);
	c_analog_out: cover property (@(posedge clk) disable iff (reset) (cmp_analog_en & third_port_drv.oe) != 4'h0);
endmodule

// [tb_gpio_ports.sv]
// testbench: port registers, directions and comparator routing
`timescale 1ns/10ps
module tb_gpio_ports;
	logic                      clk, reset, dm_bank_zero, cmp_channel_valid;
	gpio_pkg::gpio_access_t    dm_acc, rf_acc;
	gpio_pkg::gpio_pin_drive_t a_drv, b_drv, c_drv;
	logic [3:0]                dm_rdata, rf_rdata, cmp_analog_en, a_ext, b_ext, c_ext, a_pin, b_pin, c_pin;
	logic [1:0]                cmp_channel, ch;
	logic [3:0]                la, lb, lc, da, wb, dc, an, q;
	int                        failures, total_checks, seed;
	gpio_ports uut (.clk(clk), .reset(reset), .dm_acc(dm_acc), .dm_bank_zero(dm_bank_zero),
		.dm_rdata(dm_rdata), .rf_acc(rf_acc), .rf_rdata(rf_rdata), .first_port_in(a_pin),
		.first_port_drv(a_drv), .second_port_in(b_pin), .second_port_drv(b_drv), .third_port_in(c_pin),
		.third_port_drv(c_drv), .cmp_analog_en(cmp_analog_en), .cmp_channel(cmp_channel),
		.cmp_channel_valid(cmp_channel_valid));
	gpio_pin_model pins (.a_drv(a_drv), .b_drv(b_drv), .c_drv(c_drv), .a_ext(a_ext), .b_ext(b_ext),
		.c_ext(c_ext), .a_pin(a_pin), .b_pin(b_pin), .c_pin(c_pin));
	// ************************************************************
	// helpers
	// ************************************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	function automatic logic [3:0] exp_rd(input logic [3:0] dir, input logic [3:0] lat, input logic [3:0] pin);
		return (dir & lat) | (~dir & pin);
	endfunction
	task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
		total_checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// one-cycle access, read data taken the cycle after
	task automatic acc(input logic rf, input logic w, input logic [6:0] a, input logic [3:0] d);
		@(negedge clk);
		if (rf) begin
			rf_acc = '{w, !w, a, d};
		end else begin
			dm_acc = '{w, !w, a, d};
		end
		@(negedge clk);
		rf_acc = '0;
		dm_acc = '0;
		q = rf ? rf_rdata : dm_rdata;
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		repeat (8000) @(posedge clk);
		failures++;
		give_verdict;
	end
	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		reset = 1'b1;
		dm_acc = '0;
		rf_acc = '0;
		dm_bank_zero = 1'b1;
		a_ext = 4'hA;
		b_ext = 4'h5;
		c_ext = 4'hC;
		seed = $urandom(32'hE6E2);
		repeat (3) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		chk("a latch", 4'h0, a_drv.out);
		chk("a oe", 4'h0, a_drv.oe);
		chk("b latch", 4'h0, b_drv.out);
		chk("b oe", 4'h0, b_drv.oe);
		chk("c latch", 4'h0, c_drv.out);
		chk("c oe", 4'h0, c_drv.oe);
		chk("analog", 4'h0, cmp_analog_en);
		acc(1'b1, 1'b0, 7'h23, 4'h0);
		chk("rf 23", 4'h0, q);
		acc(1'b0, 1'b0, 7'h70, 4'h0);
		chk("a read", 4'hA, q);
		$display("reset test done");
		for (int i = 0; i < 40; i++) begin
			{la, lb, lc, da, wb, dc, an, ch} = 30'($urandom);
			if (i % 2 == 0) begin
				dc = dc & ~an;
			end
			{a_ext, b_ext, c_ext} = 12'($urandom);
			acc(1'b0, 1'b1, 7'h70, la);
			acc(1'b0, 1'b1, 7'h71, lb);
			acc(1'b0, 1'b1, 7'h72, lc);
			acc(1'b1, 1'b1, 7'h35, da);
			acc(1'b1, 1'b1, 7'h24, wb);
			acc(1'b1, 1'b1, 7'h34, dc);
			acc(1'b1, 1'b1, 7'h23, an);
			acc(1'b1, 1'b1, 7'h1C, {2'h3, ch});
			chk("a out", la, a_drv.out);
			chk("a oe", da, a_drv.oe);
			chk("b oe", {4{wb[0]}}, b_drv.oe);
			chk("c oe", dc, c_drv.oe);
			chk("c out", lc, c_drv.out);
			acc(1'b0, 1'b0, 7'h70, 4'h0);
			chk("a read", exp_rd(da, la, a_ext), q);
			acc(1'b0, 1'b0, 7'h71, 4'h0);
			chk("b read", exp_rd({4{wb[0]}}, lb, b_ext), q);
			acc(1'b0, 1'b0, 7'h72, 4'h0);
			chk("c read", exp_rd(dc, lc, c_ext), q);
			acc(1'b1, 1'b0, 7'h24, 4'h0);
			chk("rf 24", {3'h0, wb[0]}, q);
			acc(1'b1, 1'b0, 7'h35, 4'h0);
			chk("rf 35", da, q);
			acc(1'b1, 1'b0, 7'h1C, 4'h0);
			chk("rf 1C", {2'h0, ch}, q);
			chk("analog", an, cmp_analog_en);
			chk("channel", {2'h0, ch}, {2'h0, cmp_channel});
			chk("ch valid", {3'h0, an[ch]}, {3'h0, cmp_channel_valid});
		end
		$display("random test done");
		acc(1'b1, 1'b0, 7'h25, 4'h0);
		chk("unmapped rf", 4'h0, q);
		acc(1'b0, 1'b0, 7'h73, 4'h0);
		chk("unmapped dm", 4'h0, q);
		dm_bank_zero = 1'b0;
		acc(1'b0, 1'b1, 7'h72, ~lc);
		dm_bank_zero = 1'b1;
		chk("other bank", lc, c_drv.out);
		reset = 1'b1;
		@(negedge clk);
		reset = 1'b0;
		chk("c latch", 4'h0, c_drv.out);
		chk("analog", 4'h0, cmp_analog_en);
		chk("b oe", 4'h0, b_drv.oe);
		chk("b latch", 4'h0, b_drv.out);
		chk("a oe", 4'h0, a_drv.oe);
		chk("a latch", 4'h0, a_drv.out);
		$display("corner test done");
		give_verdict;
	end
endmodule
